// ### hsr_regs.svh
// Register offsets, field positions and reset values of the lane configuration bank
`ifndef HSR_REGS_SVH
`define HSR_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define HSR_ADDR_RX_CFG 5'h03
`define HSR_ADDR_EQ_CFG 5'h04
// ----------------------------------------
// Reset values
// ----------------------------------------
`define HSR_RX_CFG_RST 16'ha444
`define HSR_EQ_CFG_RST 16'hb820
// ----------------------------------------
// Receive configuration fields
// ----------------------------------------
`define HSR_SWING_MSB 15
`define HSR_SWING_LSB 12
`define HSR_GAIN_MSB 7
`define HSR_GAIN_LSB 6
`define HSR_CAL_MSB 5
`define HSR_CAL_LSB 4
`define HSR_UNSCR_BIT 3
`define HSR_RXEN_BIT 2
`define HSR_RATE_MSB 1
`define HSR_RATE_LSB 0
// ----------------------------------------
// Equaliser and clock recovery fields
// ----------------------------------------
`define HSR_TRACK_BIT 15
`define HSR_PRE_MSB 14
`define HSR_PRE_LSB 12
`define HSR_ORDER_MSB 11
`define HSR_ORDER_LSB 10
`define HSR_VOTE_MSB 9
`define HSR_VOTE_LSB 8
`define HSR_LIMIT_BIT 7
`define HSR_FREEZE_BIT 6
`define HSR_LOCKTAP_BIT 5
`define HSR_CURSOR_MSB 4
`define HSR_CURSOR_LSB 0
`define HSR_VOTE_BASE 6'h04
`define HSR_PRE_OFF 3'h7
`endif

// ### hsr_pkg.sv
// Types shared by the lane configuration modules
package hsr_pkg;
  // ----------------------------------------
  // Mode encodings
  // ----------------------------------------
  typedef enum logic [1:0] {GAIN_LATCH = 2'h0, GAIN_TRACK = 2'h1, GAIN_OFF = 2'h2, GAIN_ON = 2'h3} hsr_gain_mode_e;
  typedef enum logic [1:0] {CAL_AUTO = 2'h0, CAL_NONE = 2'h1, CAL_FORCE_UPD = 2'h2, CAL_FORCE = 2'h3} hsr_cal_mode_e;
  typedef enum logic [1:0] {ORD_FIRST = 2'h0, ORD_SECOND_1X = 2'h1, ORD_SECOND_2X = 2'h2, ORD_RSVD = 2'h3} hsr_cdr_order_e;
  // Gain loop state, binary coded
  typedef enum logic [1:0] {GL_ADAPT = 2'h0, GL_HOLD = 2'h1, GL_LATCHED = 2'h2} hsr_gl_state_e;
  // ----------------------------------------
  // Core state
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] rx_cfg;
    logic [15:0] eq_cfg;
    logic [15:0] rdata;
    hsr_gl_state_e gl;
    logic rx_on;
    logic cal_start;
    logic cal_force;
    logic cal_auto;
    logic att_adapt;
    logic att_off;
    logic att_on;
    logic pre_en;
    logic [3:0] pre_ninths;
    logic cdr_2nd;
    logic cdr_2x;
    logic cdr_rsvd;
    logic [5:0] votes;
  } hsr_core_s;
endpackage : hsr_pkg

// ### hsr_lane_if.sv
// Signals passed between the lane core, the pin synchroniser and the swing table
`timescale 1ns/100ps
interface hsr_lane_if #(
  parameter int MV_W = 11
);
  logic pd_n_clean;
  logic [3:0] swing_code;
  logic [MV_W-1:0] swing_mv;
  modport sync (output pd_n_clean);
  modport lut (input swing_code, output swing_mv);
  modport core (input pd_n_clean, input swing_mv, output swing_code);
endinterface : hsr_lane_if

// ### hsr_pin_sync.sv
// Three-stage synchroniser for the channel power-down pin
`timescale 1ns/100ps
module hsr_pin_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Pin and clean level
  input wire logic pin_n,
  hsr_lane_if.sync lane
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic clean;
  } hsr_sync_s;
  hsr_sync_s s_q;
  hsr_sync_s s_d;
  // Shift the pin in, accept a level once stages two and three agree
  always_comb
  begin
    s_d = s_q;
    if (ce)
    begin
      s_d.s1 = pin_n;
      s_d.s2 = s_q.s1;
      s_d.s3 = s_q.s2;
      if (s_q.s2 == s_q.s3)
      begin
        s_d.clean = s_q.s3;
      end
    end
  end
  // State register, powered down until the pin is seen
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign lane.pd_n_clean = s_q.clean;
endmodule : hsr_pin_sync

// ### hsr_swing_lut.sv
// Transmit swing code to typical amplitude table
`timescale 1ns/100ps
module hsr_swing_lut #(
  parameter int MV_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Code in, amplitude out
  hsr_lane_if.lut lane
);
  typedef struct packed {
    logic [MV_W-1:0] mv;
  } hsr_lut_s;
  hsr_lut_s s_q;
  hsr_lut_s s_d;
  logic [10:0] mv_t;
  // Monotonic table in mV peak to peak
  always_comb
  begin
    case (lane.swing_code)
      4'h0: mv_t = 11'd130; // R7
      4'h1: mv_t = 11'd220;
      4'h2: mv_t = 11'd300;
      4'h3: mv_t = 11'd390;
      4'h4: mv_t = 11'd480;
      4'h5: mv_t = 11'd570;
      4'h6: mv_t = 11'd660;
      4'h7: mv_t = 11'd750;
      4'h8: mv_t = 11'd830;
      4'h9: mv_t = 11'd930;
      4'ha: mv_t = 11'd1020;
      4'hb: mv_t = 11'd1110;
      4'hc: mv_t = 11'd1180;
      4'hd: mv_t = 11'd1270;
      4'he: mv_t = 11'd1340;
      default: mv_t = 11'd1400;
    endcase
    s_d = s_q;
    if (ce)
    begin
      s_d.mv = MV_W'(mv_t);
    end
  end
  // Amplitude register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign lane.swing_mv = s_q.mv;
endmodule : hsr_swing_lut

// ### hsr_lane_cfg.sv
// Lane receive, equaliser and clock recovery configuration bank
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`include "hsr_regs.svh"
// Operation
// R1 - Gain field picks latch, track, off, on
// R2 - Offset calibration auto, off, forced variants
// R3 - Bit allows unscrambled data, resets zero
// R4 - Receiver enable bit, resets to one
// R5 - Power-down pin or control disables receiver
// R6 - Rate field selects full to eighth
// R7 - Swing code maps monotonically to amplitude
// R8 - Track bit forces converter tracking, resets one
// R9 - Precursor odd ninths, code seven disables
// R10 - Recovery order first, second 1x, 2x
// R11 - Vote threshold four to thirty-two
// R12 - Limit bit restricts feedback tap weights
// R13 - Hold bit freezes equaliser and tail
// R14 - Lock tap bit selects h(-1) or h(+1)
// R15 - Five-bit cursor reduction, resets zero
// R16 - Receive register resets to a444
// R17 - Equaliser register resets to b820
// R18 - Both registers read back last write
// R19 - Lock tap resets to h(+1)
module hsr_lane_cfg #(
  parameter int AW = 5,
  parameter int MV_W = 11
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Power-down and lock inputs
  input wire logic channel_powerdown_n,
  input wire logic ctrl_powerdown,
  input wire logic agc_locked,
  // Receiver controls
  output logic rx_lane_on,
  output logic [1:0] rx_rate_select,
  output logic unscrambled_rx_enable,
  output logic atten_adapt_en,
  output logic atten_force_off,
  output logic atten_force_on,
  output logic offset_cal_start,
  output logic offset_cal_force,
  output logic offset_cal_auto_update,
  // Transmit controls
  output logic [3:0] tx_swing_code,
  output logic [MV_W-1:0] tx_swing_mv,
  output logic [4:0] tx_cursor_reduction,
  // Equaliser and clock recovery controls
  output logic adc_track_force,
  output logic eq_pre_enable,
  output logic [3:0] eq_pre_ninths,
  output logic cdr_second_order,
  output logic cdr_freq_2x,
  output logic cdr_order_reserved,
  output logic [5:0] cdr_vote_count,
  output logic dfe_weight_limit,
  output logic eq_freeze,
  output logic cdr_lock_tap_sel
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  hsr_pkg::hsr_core_s s_q;
  hsr_pkg::hsr_core_s s_d;
  hsr_pkg::hsr_gain_mode_e gain_d;
  hsr_pkg::hsr_cal_mode_e cal_d;
  hsr_pkg::hsr_cdr_order_e ord_d;
  logic [15:0] rx_d;
  logic [15:0] eq_d;
  hsr_lane_if #(.MV_W(MV_W)) lane ();

  // Address match used by both write and read decode
  function automatic logic hit(input logic [AW-1:0] a, input logic [4:0] off);
    hit = (a == AW'(off));
  endfunction : hit

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  hsr_pin_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .pin_n(channel_powerdown_n),
    .lane(lane)
  );
  hsr_swing_lut #(.MV_W(MV_W)) u_lut (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .lane(lane)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Register writes, read capture, decoded controls
  always_comb
  begin
    s_d = s_q;
    rx_d = s_q.rx_cfg;
    eq_d = s_q.eq_cfg;
    if (ce && reg_wr && hit(reg_addr, `HSR_ADDR_RX_CFG))
    begin
      rx_d = reg_wdata; // R18
    end
    if (ce && reg_wr && hit(reg_addr, `HSR_ADDR_EQ_CFG))
    begin
      eq_d = reg_wdata; // R18
    end
    gain_d = hsr_pkg::hsr_gain_mode_e'(rx_d[`HSR_GAIN_MSB:`HSR_GAIN_LSB]);
    cal_d = hsr_pkg::hsr_cal_mode_e'(rx_d[`HSR_CAL_MSB:`HSR_CAL_LSB]);
    ord_d = hsr_pkg::hsr_cdr_order_e'(eq_d[`HSR_ORDER_MSB:`HSR_ORDER_LSB]);
    if (ce)
    begin
      s_d.rx_cfg = rx_d;
      s_d.eq_cfg = eq_d;
      // Read data valid only in the cycle after the strobe
      s_d.rdata = 16'h0000;
      if (reg_rd && hit(reg_addr, `HSR_ADDR_RX_CFG))
      begin
        s_d.rdata = s_q.rx_cfg; // R18
      end
      else if (reg_rd && hit(reg_addr, `HSR_ADDR_EQ_CFG))
      begin
        s_d.rdata = s_q.eq_cfg; // R18
      end
      // Receiver on only when enabled and not powered down
      s_d.rx_on = rx_d[`HSR_RXEN_BIT] && lane.pd_n_clean && !ctrl_powerdown; // R4 R5
      // Calibration starts on each receiver turn-on in auto mode
      s_d.cal_start = s_d.rx_on && !s_q.rx_on && (cal_d == hsr_pkg::CAL_AUTO); // R2
      s_d.cal_force = (cal_d == hsr_pkg::CAL_FORCE_UPD) || (cal_d == hsr_pkg::CAL_FORCE); // R2
      s_d.cal_auto = (cal_d == hsr_pkg::CAL_FORCE_UPD); // R2
      // Gain loop: adapt, hold while locked, or latch after first lock
      case (s_q.gl)
        hsr_pkg::GL_ADAPT:
        begin
          if (s_d.rx_on && !gain_d[1] && agc_locked)
          begin
            s_d.gl = (gain_d == hsr_pkg::GAIN_LATCH) ? hsr_pkg::GL_LATCHED : hsr_pkg::GL_HOLD; // R1
          end
        end
        hsr_pkg::GL_HOLD:
        begin
          if (!s_d.rx_on || gain_d[1])
          begin
            s_d.gl = hsr_pkg::GL_ADAPT;
          end
          else if (gain_d == hsr_pkg::GAIN_LATCH)
          begin
            s_d.gl = hsr_pkg::GL_LATCHED; // R1
          end
          else if (!agc_locked)
          begin
            s_d.gl = hsr_pkg::GL_ADAPT; // R1
          end
        end
        hsr_pkg::GL_LATCHED:
        begin
          if (!s_d.rx_on || gain_d != hsr_pkg::GAIN_LATCH)
          begin
            s_d.gl = hsr_pkg::GL_ADAPT; // R1
          end
        end
        default:
        begin
          s_d.gl = hsr_pkg::GL_ADAPT;
        end
      endcase
      s_d.att_adapt = (s_d.gl == hsr_pkg::GL_ADAPT) && !gain_d[1]; // R1
      s_d.att_off = (gain_d == hsr_pkg::GAIN_OFF); // R1
      s_d.att_on = (gain_d == hsr_pkg::GAIN_ON); // R1
      // Precursor numerator is the odd value 2n+1
      s_d.pre_en = (eq_d[`HSR_PRE_MSB:`HSR_PRE_LSB] != `HSR_PRE_OFF); // R9
      s_d.pre_ninths = {eq_d[`HSR_PRE_MSB:`HSR_PRE_LSB], 1'b1}; // R9
      // Recovery order decode, reserved code flagged
      s_d.cdr_2nd = (ord_d == hsr_pkg::ORD_SECOND_1X) || (ord_d == hsr_pkg::ORD_SECOND_2X); // R10
      s_d.cdr_2x = (ord_d == hsr_pkg::ORD_SECOND_2X); // R10
      s_d.cdr_rsvd = (ord_d == hsr_pkg::ORD_RSVD); // R10
      // Votes double per code step
      s_d.votes = `HSR_VOTE_BASE << eq_d[`HSR_VOTE_MSB:`HSR_VOTE_LSB]; // R11
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset brings every field to its default
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.rx_cfg <= `HSR_RX_CFG_RST; // R16 R3 R4 R6
      s_q.eq_cfg <= `HSR_EQ_CFG_RST; // R17 R8 R15 R19
      s_q.gl <= hsr_pkg::GL_ADAPT;
      s_q.att_adapt <= 1'b1;
      s_q.pre_en <= 1'b1;
      s_q.pre_ninths <= 4'h7;
      s_q.cdr_2nd <= 1'b1;
      s_q.cdr_2x <= 1'b1;
      s_q.votes <= `HSR_VOTE_BASE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data, receiver on, table amplitude and fields straight from the registers
  assign reg_rdata = s_q.rdata;
  assign rx_lane_on = s_q.rx_on;
  assign rx_rate_select = s_q.rx_cfg[`HSR_RATE_MSB:`HSR_RATE_LSB]; // R6
  assign unscrambled_rx_enable = s_q.rx_cfg[`HSR_UNSCR_BIT]; // R3
  assign lane.swing_code = s_q.rx_cfg[`HSR_SWING_MSB:`HSR_SWING_LSB]; // R7
  assign tx_swing_code = s_q.rx_cfg[`HSR_SWING_MSB:`HSR_SWING_LSB];
  assign tx_swing_mv = lane.swing_mv;
  assign tx_cursor_reduction = s_q.eq_cfg[`HSR_CURSOR_MSB:`HSR_CURSOR_LSB]; // R15
  assign adc_track_force = s_q.eq_cfg[`HSR_TRACK_BIT]; // R8
  assign dfe_weight_limit = s_q.eq_cfg[`HSR_LIMIT_BIT]; // R12
  assign eq_freeze = s_q.eq_cfg[`HSR_FREEZE_BIT]; // R13
  assign cdr_lock_tap_sel = s_q.eq_cfg[`HSR_LOCKTAP_BIT]; // R14
  // Decoded controls
  assign atten_adapt_en = s_q.att_adapt;
  assign atten_force_off = s_q.att_off;
  assign atten_force_on = s_q.att_on;
  assign offset_cal_start = s_q.cal_start;
  assign offset_cal_force = s_q.cal_force;
  assign offset_cal_auto_update = s_q.cal_auto;
  assign eq_pre_enable = s_q.pre_en;
  assign eq_pre_ninths = s_q.pre_ninths;
  assign cdr_second_order = s_q.cdr_2nd;
  assign cdr_freq_2x = s_q.cdr_2x;
  assign cdr_order_reserved = s_q.cdr_rsvd;
  assign cdr_vote_count = s_q.votes;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset values seen on the first edge after release
  a_reset_values: assert property (!$past(rst_n) |-> s_q.rx_cfg == 16'ha444 && s_q.eq_cfg == 16'hb820) // R16
    else $error("register reset value wrong");
  a_lock_tap_rst: assert property (!$past(rst_n) |-> cdr_lock_tap_sel && adc_track_force) // R19
    else $error("lock tap or track reset wrong");
  // Write then read returns the written word two cycles later
  a_write_readback: assert property (ce && reg_wr && reg_addr == AW'(5'h04) ##1 ce && reg_rd && reg_addr == AW'(5'h04)
    |=> reg_rdata == $past(reg_wdata, 2)) // R18
    else $error("read back differs from write");
  a_read_idle: assert property (!$past(reg_rd) && $past(ce) |-> reg_rdata == 16'h0000) // R18
    else $error("read data outside its cycle");
  // Power-down overrides the enable bit
  a_powerdown_gate: assert property (ce && (!lane.pd_n_clean || ctrl_powerdown) |=> !rx_lane_on) // R5
    else $error("receiver on while powered down");
  a_enable_off: assert property (ce && reg_wr && reg_addr == AW'(5'h03) && !reg_wdata[2] |=> !rx_lane_on) // R4
    else $error("receiver on with enable clear");
  // Latched gain loop ignores loss of lock
  a_gain_latched: assert property (ce && s_q.gl == hsr_pkg::GL_LATCHED && rx_lane_on && !reg_wr && lane.pd_n_clean
    && !ctrl_powerdown && !agc_locked |=> !atten_adapt_en) // R1
    else $error("latched attenuator adapted");
  a_gain_forced: assert property (ce && reg_wr && reg_addr == AW'(5'h03) && reg_wdata[7:6] == 2'h2
    |=> atten_force_off && !atten_force_on && !atten_adapt_en) // R1
    else $error("attenuator force off wrong");
  // Calibration pulse in the same cycle as receiver turn-on
  a_cal_start: assert property ($rose(rx_lane_on) && s_q.rx_cfg[5:4] == 2'h0 |-> offset_cal_start) // R2
    else $error("calibration did not start");
  a_cal_forced: assert property (ce && reg_wr && reg_addr == AW'(5'h03) && reg_wdata[5:4] == 2'h3
    |=> offset_cal_force && !offset_cal_auto_update && !offset_cal_start) // R2
    else $error("forced calibration decode wrong");
  // Vote count and precursor decode from the written word
  a_vote_count: assert property (ce && reg_wr && reg_addr == AW'(5'h04)
    |=> cdr_vote_count == (6'h04 << $past(reg_wdata[9:8]))) // R11
    else $error("vote count wrong");
  a_precursor: assert property (ce && reg_wr && reg_addr == AW'(5'h04)
    |=> eq_pre_enable == ($past(reg_wdata[14:12]) != 3'h7) && eq_pre_ninths == {$past(reg_wdata[14:12]), 1'b1}) // R9
    else $error("precursor decode wrong");
  a_cdr_order: assert property (ce && reg_wr && reg_addr == AW'(5'h04) && reg_wdata[11:10] == 2'h0
    |=> !cdr_second_order && !cdr_freq_2x && !cdr_order_reserved) // R10
    else $error("first order decode wrong");
  a_freeze_limit: assert property (ce && reg_wr && reg_addr == AW'(5'h04)
    |=> eq_freeze == $past(reg_wdata[6]) && dfe_weight_limit == $past(reg_wdata[7])) // R12 R13
    else $error("equaliser control bits wrong");
  a_rate_cursor: assert property (ce && reg_wr
    |=> (rx_rate_select == $past(s_d.rx_cfg[1:0])) && tx_cursor_reduction == $past(s_d.eq_cfg[4:0])) // R6 R15
    else $error("rate or cursor field wrong");
  a_swing_order: assert property (ce ##1 ce && tx_swing_code == 4'hf |=> tx_swing_mv == MV_W'(1400)) // R7
    else $error("swing top code wrong");
  a_unscrambled: assert property (ce && reg_wr && reg_addr == AW'(5'h03)
    |=> unscrambled_rx_enable == $past(reg_wdata[3]) && cdr_lock_tap_sel == $past(s_q.eq_cfg[5])) // R3 R14
    else $error("unscrambled or lock tap bit wrong");
  // Main scenarios
  c_cal_start: cover property (offset_cal_start);
  c_gain_latched: cover property (s_q.gl == hsr_pkg::GL_LATCHED && !agc_locked);
  c_powerdown: cover property ($fell(rx_lane_on));
  c_readback: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule : hsr_lane_cfg

// ### test_hsr_lane_cfg.sv
// Self-checking testbench for the lane configuration register bank
`timescale 1ns/100ps
`include "hsr_regs.svh"
module test_hsr_lane_cfg;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic channel_powerdown_n = 1'b1;
  logic ctrl_powerdown = 1'b0;
  logic agc_locked = 1'b0;
  logic rx_lane_on, unscrambled_rx_enable, atten_adapt_en, atten_force_off, atten_force_on;
  logic offset_cal_start, offset_cal_force, offset_cal_auto_update, adc_track_force, eq_pre_enable;
  logic cdr_second_order, cdr_freq_2x, cdr_order_reserved, dfe_weight_limit, eq_freeze, cdr_lock_tap_sel;
  logic [1:0] rx_rate_select;
  logic [3:0] tx_swing_code;
  logic [10:0] tx_swing_mv;
  logic [4:0] tx_cursor_reduction;
  logic [3:0] eq_pre_ninths;
  logic [5:0] cdr_vote_count;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [2:0] e;
  logic [1:0] k;
  logic [15:0] w;
  // Typical amplitude in mV for each swing code
  logic [10:0] swing_tab [16] = '{11'h082, 11'h0dc, 11'h12c, 11'h186, 11'h1e0, 11'h23a, 11'h294, 11'h2ee,
                                  11'h33e, 11'h3a2, 11'h3fc, 11'h456, 11'h49c, 11'h4f6, 11'h53c, 11'h578};

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  hsr_lane_cfg #(.AW(5), .MV_W(11)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .channel_powerdown_n(channel_powerdown_n),
    .ctrl_powerdown(ctrl_powerdown), .agc_locked(agc_locked), .rx_lane_on(rx_lane_on),
    .rx_rate_select(rx_rate_select), .unscrambled_rx_enable(unscrambled_rx_enable),
    .atten_adapt_en(atten_adapt_en), .atten_force_off(atten_force_off), .atten_force_on(atten_force_on),
    .offset_cal_start(offset_cal_start), .offset_cal_force(offset_cal_force),
    .offset_cal_auto_update(offset_cal_auto_update), .tx_swing_code(tx_swing_code),
    .tx_swing_mv(tx_swing_mv), .tx_cursor_reduction(tx_cursor_reduction), .adc_track_force(adc_track_force),
    .eq_pre_enable(eq_pre_enable), .eq_pre_ninths(eq_pre_ninths), .cdr_second_order(cdr_second_order),
    .cdr_freq_2x(cdr_freq_2x), .cdr_order_reserved(cdr_order_reserved), .cdr_vote_count(cdr_vote_count),
    .dfe_weight_limit(dfe_weight_limit), .eq_freeze(eq_freeze), .cdr_lock_tap_sel(cdr_lock_tap_sel)
  );

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and count
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Print counts and verdict, then stop
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // One-cycle write; fields are settled on return
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read; data stands one cycle then returns to zero
  task rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge clk);
    #1;
    check(reg_rdata, 16'h0000);
  endtask : rd

  // Bounded wait for the receiver enable to reach a level
  task wait_rx(input logic lvl);
    for (int n = 0; n < 8 && rx_lane_on !== lvl; n++)
    begin
      @(posedge clk);
      #1;
    end
    check({15'h0000, rx_lane_on}, {15'h0000, lvl});
  endtask : wait_rx

  // Receiver comes up with a one-cycle calibration start pulse
  task rx_up;
    wait_rx(1'b1);
    check({15'h0000, offset_cal_start}, 16'h0001);
    @(posedge clk);
    #1;
    check({15'h0000, offset_cal_start}, 16'h0000);
  endtask : rx_up

  // Timeout guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, power-up and unmapped accesses
    rx_up();
    check({tx_swing_code, 2'b00, rx_rate_select, 7'h00, unscrambled_rx_enable}, 16'ha000);
    check({adc_track_force, dfe_weight_limit, eq_freeze, cdr_lock_tap_sel, 7'h00, tx_cursor_reduction}, 16'h9000);
    check({eq_pre_enable, eq_pre_ninths, cdr_second_order, cdr_freq_2x, cdr_order_reserved}, 16'h00be);
    check({10'h000, cdr_vote_count}, 16'h0004);
    check({5'h00, tx_swing_mv}, 16'h03fc);
    rd(`HSR_ADDR_RX_CFG, 16'ha444);
    rd(`HSR_ADDR_EQ_CFG, 16'hb820);
    wr(5'h07, 16'h1234);
    rd(5'h07, 16'h0000);
    rd(`HSR_ADDR_RX_CFG, 16'ha444);
    $display("test reset done");
    // Every swing code and its amplitude
    for (int n = 0; n < 16; n++)
    begin
      wr(`HSR_ADDR_RX_CFG, {4'(n), 12'h444});
      check({12'h000, tx_swing_code}, 16'(n));
      @(posedge clk);
      #1;
      check({5'h00, tx_swing_mv}, {5'h00, swing_tab[n]});
    end
    $display("test swing done");
    // Rate, unscrambled and calibration codes, receiver kept on
    for (int n = 0; n < 4; n++)
    begin
      k = 2'(n);
      w = {8'ha4, 2'b00, k, k[0], 1'b1, k};
      wr(`HSR_ADDR_RX_CFG, w);
      check({14'h0000, rx_rate_select}, {14'h0000, k});
      check({15'h0000, unscrambled_rx_enable}, {15'h0000, k[0]});
      check({14'h0000, offset_cal_force, offset_cal_auto_update}, {14'h0000, k[1], k == 2'h2});
      check({15'h0000, rx_lane_on}, 16'h0001);
      rd(`HSR_ADDR_RX_CFG, w);
    end
    wr(`HSR_ADDR_RX_CFG, 16'ha440);
    wait_rx(1'b0);
    wr(`HSR_ADDR_RX_CFG, 16'ha444);
    rx_up();
    $display("test receive fields done");
    // Equaliser and clock recovery codes
    for (int n = 0; n < 8; n++)
    begin
      e = 3'(n);
      w = {e[0], e, e[1:0], e[2:1], e[1], e[2], ~e[0], e, e[1:0]};
      wr(`HSR_ADDR_EQ_CFG, w);
      check({15'h0000, adc_track_force}, {15'h0000, e[0]});
      check({11'h000, eq_pre_enable, eq_pre_ninths}, {11'h000, e != 3'h7, 4'(2 * n + 1)});
      check({13'h0000, cdr_second_order, cdr_freq_2x, cdr_order_reserved},
            {13'h0000, e[1] ^ e[0], e[1:0] == 2'h2, e[1:0] == 2'h3});
      check({10'h000, cdr_vote_count}, {10'h000, 6'(4 << e[2:1])});
      check({13'h0000, dfe_weight_limit, eq_freeze, cdr_lock_tap_sel}, {13'h0000, e[1], e[2], ~e[0]});
      check({11'h000, tx_cursor_reduction}, {11'h000, e, e[1:0]});
      rd(`HSR_ADDR_EQ_CFG, w);
    end
    $display("test equaliser fields done");
    // Gain loop modes
    @(posedge clk);
    agc_locked <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, atten_adapt_en}, 16'h0000);
    @(posedge clk);
    agc_locked <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({15'h0000, atten_adapt_en}, 16'h0001);
    wr(`HSR_ADDR_RX_CFG, 16'ha404);
    @(posedge clk);
    agc_locked <= 1'b1;
    @(posedge clk);
    agc_locked <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({15'h0000, atten_adapt_en}, 16'h0000);
    wr(`HSR_ADDR_RX_CFG, 16'ha484);
    check({13'h0000, atten_adapt_en, atten_force_off, atten_force_on}, 16'h0002);
    wr(`HSR_ADDR_RX_CFG, 16'ha4c4);
    check({13'h0000, atten_adapt_en, atten_force_off, atten_force_on}, 16'h0001);
    wr(`HSR_ADDR_RX_CFG, 16'ha444);
    $display("test gain loop done");
    // Power-down by control level, by pin, and frozen strobes
    @(posedge clk);
    ctrl_powerdown <= 1'b1;
    wait_rx(1'b0);
    @(posedge clk);
    ctrl_powerdown <= 1'b0;
    rx_up();
    @(posedge clk);
    channel_powerdown_n <= 1'b0;
    wait_rx(1'b0);
    @(posedge clk);
    channel_powerdown_n <= 1'b1;
    rx_up();
    @(posedge clk);
    ce <= 1'b0;
    wr(`HSR_ADDR_EQ_CFG, 16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    rd(`HSR_ADDR_EQ_CFG, w);
    $display("test power-down done");
    test_done();
  end
endmodule : test_hsr_lane_cfg
